// file: rtl/dmc_fade.v
/*
  Linear fade engine: moves the level one percent per fade_s ticks of 10 ms.
  Assumes fade_s is the time in seconds of a full 0-100% sweep.
*/
`include "dmc_map.vh"

module dmc_fade (
  input  wire       clock,
  input  wire       reset_n,
  input  wire       tick,
  input  wire       load,
  input  wire [7:0] target,
  input  wire [15:0] fade_s,
  output reg  [7:0] level_q,
  output reg        busy_q,
  output reg        done_q
);
  reg [7:0]  tgt_q;
  reg [15:0] cnt_q;
  reg [15:0] span_q;
  wire [7:0] next_w = (level_q < tgt_q) ? level_q + 8'h01 : level_q - 8'h01;

  always @(posedge clock) begin
    done_q <= 1'b0;
    if (!reset_n) begin
      level_q <= 8'h00;
      tgt_q   <= 8'h00;
      cnt_q   <= 16'h0000;
      span_q  <= 16'h0000;
      busy_q  <= 1'b0;
    end else if (load) begin
      tgt_q  <= target; // RQ25
      span_q <= fade_s;
      cnt_q  <= 16'h0000;
      if (fade_s == 16'h0000 || target == level_q) begin
        level_q <= target; // RQ24
        busy_q  <= 1'b0;
        done_q  <= 1'b1;
      end else begin
        busy_q <= 1'b1;
      end
    end else if (busy_q && tick) begin
      // One second per sweep equals one 10 ms tick per percent step.
      if (cnt_q + 16'h0001 >= span_q) begin // RQ19
        cnt_q   <= 16'h0000;
        level_q <= next_w; // RQ24
        if (next_w == tgt_q) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule // dmc_fade

// file: rtl/dmc_map.vh
/*
  Constants for the dimmer channel control block: codes, levels and timing counts.
  Assumes a 125 MHz system clock and levels held as whole percent from 0 to 100.
*/
// Summary of operation
// RQ1: Function selects disabled, dimmer or staircase; staircase allows only the lock feature.
// RQ2: Dimmer function offers scene, automatic, slumber and lock; staircase keeps lock.
// RQ3: Disabled state reporting never sends either state output.
// RQ4: Read-only reporting sends state outputs only when a read is requested.
// RQ5: On/off state sends OFF on reaching 0%, ON on leaving 0%.
// RQ6: Brightness state sends on 1% change or fade end, at least 1 s apart.
// RQ7: Cyclic mode sends on change and again every configured cycle interval.
// RQ8: On/off state is one bit; brightness state is an 8-bit percentage.
// RQ9: Bus power loss leaves the output alone or fades to a configured level.
// RQ10: Every restart applies no reaction, a fixed level, or the pre-failure level.
// RQ11: Active automatic mode drives brightness from automatic set-values.
// RQ12: Manual commands override automatic mode and restart the fallback timer.
// RQ13: After the fallback time expires, automatic set-values are obeyed again.
// RQ14: Automatic-activate switches automatic mode anytime and reports its state.
// RQ15: Slumber offers two fade durations each for switching on and off.
// RQ16: Scenes numbered 1 to 16 are supported when the scene feature is on.
// RQ17: ON while off: no reaction, fixed ON level, or last level before off.
// RQ18: ON while on: no reaction, fixed ON level, or fixed level if higher.
// RQ19: Fade time is for a full 0-100% sweep; shorter moves take proportionally less.
// RQ20: OFF gives no reaction or a fade to the OFF level with the OFF fade time.
// RQ21: Enabled second OFF switches fully off only within 1 s of the first.
// RQ22: First OFF at or below the OFF level switches off immediately.
// RQ23: Day/night input: ON selects day, OFF night; day after every restart.
// RQ24: Fade steps linearly at a rate from the fade time; zero fade is immediate.
// RQ25: A new brightness command aborts a running fade and starts a fresh one.
`ifndef DMC_MAP_VH
`define DMC_MAP_VH

`define DMC_CLK_NS        8
`define DMC_TICK_NS       10000000
// Written out at the counter width so that no parameter takes a wider integer.
`define DMC_TICK_CYC      21'h1312D0
`define DMC_TICKS_PER_S   7'h64
`define DMC_GAP_TICKS     7'h65
`define DMC_OFF2_TICKS    7'h64

`define DMC_FN_OFF        2'h0
`define DMC_FN_DIM        2'h1
`define DMC_FN_STAIR      2'h2

`define DMC_SEND_NONE     2'h0
`define DMC_SEND_READ     2'h1
`define DMC_SEND_CHG      2'h2
`define DMC_SEND_CYC      2'h3

`define DMC_BEH_NONE      2'h0
`define DMC_BEH_FIX       2'h1
`define DMC_BEH_ALT       2'h2

`define DMC_LVL_FULL      8'h64
`define DMC_SCENE_COUNT   6'h10

`endif

// file: rtl/dmc_tick.v
/*
  Time base for the dimmer channel: a 10 ms enable pulse and a 1 s enable pulse.
  Assumes one free-running clock; the 10 ms count is a parameter for short simulations.
*/
`include "dmc_map.vh"

module dmc_tick #(
  parameter [20:0] TICK_CYC = `DMC_TICK_CYC
) (
  input  wire clock,
  input  wire reset_n,
  output reg  tick_q,
  output reg  sec_q
);
  reg [20:0] cnt_q;
  reg [6:0]  sub_q;

  always @(posedge clock) begin
    tick_q <= 1'b0;
    sec_q  <= 1'b0;
    if (!reset_n) begin
      cnt_q <= 21'h000000;
      sub_q <= 7'h00;
    end else if (cnt_q == TICK_CYC - 21'h000001) begin
      cnt_q  <= 21'h000000;
      tick_q <= 1'b1;
      if (sub_q == `DMC_TICKS_PER_S - 7'h01) begin
        sub_q <= 7'h00;
        sec_q <= 1'b1;
      end else begin
        sub_q <= sub_q + 7'h01;
      end
    end else begin
      cnt_q <= cnt_q + 21'h000001;
    end
  end
endmodule // dmc_tick

// file: rtl/dmc_top.v
/*
  Control of one dimmer channel: switch, scene, slumber, override and automatic
  commands set a target, a fade engine moves the level, state reports go out as pulses.
  Assumes every input is synchronous to clock and command valids are one-cycle pulses.
*/
`include "dmc_map.vh"

module dmc_top #(
  parameter [20:0] TICK_CYC = `DMC_TICK_CYC
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [1:0]  cfg_function,
  input  wire        cfg_scene_en,
  input  wire        cfg_auto_en,
  input  wire        cfg_slumber_en,
  input  wire        cfg_lock_en,
  input  wire [1:0]  cfg_send_mode,
  input  wire [15:0] cfg_cycle_s,
  input  wire        cfg_fail_dim,
  input  wire [7:0]  cfg_fail_level,
  input  wire [1:0]  cfg_return_mode,
  input  wire [7:0]  cfg_return_level,
  input  wire [1:0]  cfg_on_off_beh,
  input  wire [1:0]  cfg_on_on_beh,
  input  wire [7:0]  cfg_on_level,
  input  wire [7:0]  cfg_night_on_level,
  input  wire [15:0] cfg_on_fade_s,
  input  wire        cfg_off_dim,
  input  wire [7:0]  cfg_off_level,
  input  wire [7:0]  cfg_night_off_level,
  input  wire [15:0] cfg_off_fade_s,
  input  wire        cfg_off2_en,
  input  wire [15:0] cfg_fallback_s,
  input  wire [15:0] cfg_slp_on_fade0_s,
  input  wire [15:0] cfg_slp_on_fade1_s,
  input  wire [15:0] cfg_slp_off_fade0_s,
  input  wire [15:0] cfg_slp_off_fade1_s,
  input  wire        restart,
  input  wire        bus_fail,
  input  wire        sw_valid,
  input  wire        sw_value,
  input  wire        scene_valid,
  input  wire [5:0]  scene_num,
  input  wire [7:0]  scene_level,
  input  wire        slumber_valid,
  input  wire        slumber_on,
  input  wire        slumber_sel,
  input  wire        ovr_valid,
  input  wire [7:0]  ovr_level,
  input  wire [15:0] ovr_fade_s,
  input  wire        auto_act_valid,
  input  wire        auto_act_value,
  input  wire        auto_val_valid,
  input  wire [7:0]  auto_val,
  input  wire        day_night_valid,
  input  wire        day_night_value,
  input  wire        read_req,
  output wire        avail_scene,
  output wire        avail_auto,
  output wire        avail_slumber,
  output wire        avail_lock,
  output wire [7:0]  level,
  output wire        fading,
  output reg         night_q,
  output reg         auto_on_q,
  output reg         ovr_q,
  output reg         auto_st_send_q,
  output reg         st_sw_send_q,
  output reg         st_sw_value_q,
  output reg         st_val_send_q,
  output reg  [7:0]  st_val_value_q
);
  function [7:0] dmc_clip;
    input [7:0] v;
    dmc_clip = (v > `DMC_LVL_FULL) ? `DMC_LVL_FULL : v;
  endfunction

  wire dim_fn   = (cfg_function == `DMC_FN_DIM);
  wire stair_fn = (cfg_function == `DMC_FN_STAIR);
  assign avail_scene   = dim_fn & cfg_scene_en; // RQ2
  assign avail_auto    = dim_fn & cfg_auto_en; // RQ2
  assign avail_slumber = dim_fn & cfg_slumber_en; // RQ2
  assign avail_lock    = (dim_fn | stair_fn) & cfg_lock_en; // RQ1

  wire tick_w;
  wire sec_w;
  wire fade_done_w;
  wire [7:0] lvl_w;
  reg        ld;
  reg  [7:0] ld_tgt;
  reg  [15:0] ld_fade;
  reg        man;
  reg        off_first;
  reg        off_second;

  dmc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clock   (clock),
    .reset_n (reset_n),
    .tick_q  (tick_w),
    .sec_q   (sec_w)
  );

  dmc_fade u_fade (
    .clock   (clock),
    .reset_n (reset_n),
    .tick    (tick_w),
    .load    (ld),
    .target  (ld_tgt),
    .fade_s  (ld_fade),
    .level_q (lvl_w),
    .busy_q  (fading),
    .done_q  (fade_done_w)
  );
  assign level = lvl_w;

  reg [7:0]  last_on_q;
  reg [7:0]  saved_q;
  reg [6:0]  off_win_q;
  reg [15:0] fb_cnt_q;

  wire [7:0] on_lvl  = dmc_clip(night_q ? cfg_night_on_level : cfg_on_level);
  wire [7:0] off_lvl = dmc_clip(night_q ? cfg_night_off_level : cfg_off_level);
  wire scene_ok = avail_scene & scene_valid & (scene_num < `DMC_SCENE_COUNT); // RQ16
  wire slp_ok   = avail_slumber & slumber_valid;
  wire auto_ok  = avail_auto & auto_on_q & ~ovr_q & auto_val_valid; // RQ11

  // Command arbitration; a restart or power event outranks telegrams in the same cycle.
  always @* begin
    ld         = 1'b0;
    ld_tgt     = lvl_w;
    ld_fade    = 16'h0000;
    man        = 1'b0;
    off_first  = 1'b0;
    off_second = 1'b0;
    if (restart) begin
      case (cfg_return_mode) // RQ10
        `DMC_BEH_FIX: begin
          ld      = 1'b1;
          ld_tgt  = dmc_clip(cfg_return_level);
          ld_fade = cfg_on_fade_s;
        end
        `DMC_BEH_ALT: begin
          ld      = 1'b1;
          ld_tgt  = saved_q;
          ld_fade = cfg_on_fade_s;
        end
        default: ld = 1'b0;
      endcase
    end else if (bus_fail) begin
      if (cfg_fail_dim) begin // RQ9
        ld      = 1'b1;
        ld_tgt  = dmc_clip(cfg_fail_level);
        ld_fade = cfg_off_fade_s;
      end
    end else if (dim_fn && sw_valid) begin
      man = 1'b1; // RQ12
      if (sw_value) begin
        ld_fade = cfg_on_fade_s;
        if (lvl_w == 8'h00) begin
          case (cfg_on_off_beh) // RQ17
            `DMC_BEH_FIX: begin
              ld     = 1'b1;
              ld_tgt = on_lvl;
            end
            `DMC_BEH_ALT: begin
              ld     = 1'b1;
              ld_tgt = (last_on_q == 8'h00) ? on_lvl : last_on_q;
            end
            default: ld = 1'b0;
          endcase
        end else begin
          case (cfg_on_on_beh) // RQ18
            `DMC_BEH_FIX: begin
              ld     = 1'b1;
              ld_tgt = on_lvl;
            end
            `DMC_BEH_ALT: begin
              ld     = (on_lvl > lvl_w);
              ld_tgt = on_lvl;
            end
            default: ld = 1'b0;
          endcase
        end
      end else if (cfg_off2_en && off_win_q != 7'h00) begin
        off_second = 1'b1;
        ld         = 1'b1; // RQ21
        ld_tgt     = 8'h00;
      end else begin
        off_first = 1'b1;
        if (lvl_w <= off_lvl) begin
          ld     = 1'b1; // RQ22
          ld_tgt = 8'h00;
        end else if (cfg_off_dim) begin
          ld      = 1'b1; // RQ20
          ld_tgt  = off_lvl;
          ld_fade = cfg_off_fade_s;
        end
      end
    end else if (scene_ok) begin
      man     = avail_auto;
      ld      = 1'b1;
      ld_tgt  = dmc_clip(scene_level);
      ld_fade = cfg_on_fade_s;
    end else if (slp_ok) begin
      man    = avail_auto;
      ld     = 1'b1;
      ld_tgt = slumber_on ? on_lvl : 8'h00;
      if (slumber_on) begin
        ld_fade = slumber_sel ? cfg_slp_on_fade1_s : cfg_slp_on_fade0_s; // RQ15
      end else begin
        ld_fade = slumber_sel ? cfg_slp_off_fade1_s : cfg_slp_off_fade0_s; // RQ15
      end
    end else if (dim_fn && ovr_valid) begin
      man     = 1'b1;
      ld      = 1'b1; // RQ25
      ld_tgt  = dmc_clip(ovr_level);
      ld_fade = ovr_fade_s;
    end else if (auto_ok) begin
      ld      = 1'b1; // RQ11
      ld_tgt  = dmc_clip(auto_val);
      ld_fade = cfg_on_fade_s;
    end
  end

  // Remembered levels and the second-OFF window.
  always @(posedge clock) begin
    if (!reset_n) begin
      last_on_q <= 8'h00;
      saved_q   <= 8'h00;
      off_win_q <= 7'h00;
    end else begin
      if (off_first && lvl_w != 8'h00) begin
        last_on_q <= lvl_w;
      end
      if (bus_fail && !restart) begin
        saved_q <= lvl_w;
      end
      if (off_first) begin
        off_win_q <= `DMC_OFF2_TICKS; // RQ21
      end else if (off_second || restart) begin
        off_win_q <= 7'h00;
      end else if (tick_w && off_win_q != 7'h00) begin
        off_win_q <= off_win_q - 7'h01;
      end
    end
  end

  // Day/night selection; a restart forces day mode.
  always @(posedge clock) begin
    if (!reset_n) begin
      night_q <= 1'b0;
    end else if (restart) begin
      night_q <= 1'b0; // RQ23
    end else if (dim_fn && day_night_valid) begin
      night_q <= ~day_night_value; // RQ23
    end
  end

  // Automatic mode and its manual-override fallback timer.
  always @(posedge clock) begin
    auto_st_send_q <= 1'b0;
    if (!reset_n) begin
      auto_on_q <= 1'b0;
      ovr_q     <= 1'b0;
      fb_cnt_q  <= 16'h0000;
    end else if (!avail_auto) begin
      auto_on_q <= 1'b0;
      ovr_q     <= 1'b0;
    end else begin
      if (auto_act_valid) begin
        auto_on_q      <= auto_act_value; // RQ14
        auto_st_send_q <= 1'b1; // RQ14
        if (auto_act_value) begin
          ovr_q <= 1'b0;
        end
      end
      if (man && auto_on_q) begin
        ovr_q    <= 1'b1; // RQ12
        fb_cnt_q <= cfg_fallback_s; // RQ12
      end else if (ovr_q && sec_w) begin
        if (fb_cnt_q <= 16'h0001) begin
          ovr_q <= 1'b0; // RQ13
        end
        if (fb_cnt_q != 16'h0000) begin
          fb_cnt_q <= fb_cnt_q - 16'h0001;
        end
      end
    end
  end

  // State reporting.
  reg        was_zero_q;
  reg [7:0]  sent_q;
  reg        val_pend_q;
  reg [6:0]  gap_q;
  reg [15:0] cyc_q;

  wire rep_on   = (cfg_function != `DMC_FN_OFF) && (cfg_send_mode != `DMC_SEND_NONE); // RQ3
  wire chg_mode = (cfg_send_mode == `DMC_SEND_CHG) || (cfg_send_mode == `DMC_SEND_CYC);
  wire is_zero  = (lvl_w == 8'h00);
  wire rd_now   = rep_on & read_req; // RQ4
  wire cyc_now  = rep_on & (cfg_send_mode == `DMC_SEND_CYC) & sec_w & (cyc_q <= 16'h0001);
  wire sw_chg   = rep_on & chg_mode & (is_zero != was_zero_q); // RQ5
  wire val_chg  = (lvl_w != sent_q) | fade_done_w;
  wire val_now  = rep_on & chg_mode & (val_pend_q | val_chg) & (gap_q == 7'h00);

  always @(posedge clock) begin
    st_sw_send_q  <= 1'b0;
    st_val_send_q <= 1'b0;
    if (!reset_n) begin
      was_zero_q     <= 1'b1;
      sent_q         <= 8'h00;
      val_pend_q     <= 1'b0;
      gap_q          <= 7'h00;
      cyc_q          <= 16'h0000;
      st_sw_value_q  <= 1'b0;
      st_val_value_q <= 8'h00;
    end else begin
      was_zero_q <= is_zero;
      if (sw_chg || rd_now || cyc_now) begin
        st_sw_send_q  <= 1'b1; // RQ8
        st_sw_value_q <= ~is_zero; // RQ5
      end
      if (cfg_send_mode != `DMC_SEND_CYC) begin
        cyc_q <= cfg_cycle_s;
      end else if (sec_w) begin
        cyc_q <= (cyc_q <= 16'h0001) ? cfg_cycle_s : cyc_q - 16'h0001; // RQ7
      end
      if (val_now || rd_now || cyc_now) begin
        st_val_send_q  <= 1'b1; // RQ8
        st_val_value_q <= lvl_w;
        sent_q         <= lvl_w;
        val_pend_q     <= 1'b0;
      end else if (chg_mode && val_chg) begin
        val_pend_q <= 1'b1;
      end
      // One tick extra keeps the spacing at or above a full second.
      if (val_now) begin
        gap_q <= `DMC_GAP_TICKS; // RQ6
      end else if (tick_w && gap_q != 7'h00) begin
        gap_q <= gap_q - 7'h01;
      end
    end
  end
endmodule // dmc_top

// file: test/dmc_knx_sender.sv
/*
  Model of the other bus devices: sends group telegrams as one-cycle command pulses.
  Assumes the testbench calls send; data lines other than scene_num and ovr_fade_s are scrambled once a pulse ends.
*/
module dmc_knx_sender (
  input  wire         clock,
  output logic        sw_valid = 1'b0,
  output logic        sw_value = 1'b0,
  output logic        scene_valid = 1'b0,
  output logic [5:0]  scene_num = 6'h00,
  output logic [7:0]  scene_level = 8'h00,
  output logic        ovr_valid = 1'b0,
  output logic [7:0]  ovr_level = 8'h00,
  output logic [15:0] ovr_fade_s = 16'h0000,
  output logic        auto_act_valid = 1'b0,
  output logic        auto_act_value = 1'b0,
  output logic        auto_val_valid = 1'b0,
  output logic [7:0]  auto_val = 8'h00,
  output logic        read_req = 1'b0
);
  timeunit 1ns;
  timeprecision 1ps;
  // Kind: 0 switch, 1 scene, 2 brightness, 3 auto activate, 4 auto value, 5 read.
  task automatic send(input int k, input logic [15:0] a, input logic [15:0] b);
    @(negedge clock);
    case (k)
      0: {sw_valid, sw_value} = {1'b1, a[0]};
      1: {scene_valid, scene_num, scene_level} = {1'b1, a[5:0], b[7:0]};
      2: {ovr_valid, ovr_level, ovr_fade_s} = {1'b1, a[7:0], b};
      3: {auto_act_valid, auto_act_value} = {1'b1, a[0]};
      4: {auto_val_valid, auto_val} = {1'b1, a[7:0]};
      default: read_req = 1'b1;
    endcase
    @(negedge clock);
    {sw_valid, scene_valid, ovr_valid, auto_act_valid, auto_val_valid, read_req} = 6'h00;
    // Stale data must not look valid, so it is inverted rather than held.
    {sw_value, scene_level, ovr_level, auto_act_value, auto_val} =
      ~{sw_value, scene_level, ovr_level, auto_act_value, auto_val};
  endtask
endmodule // dmc_knx_sender

// file: test/dmc_top_monitor.sv
/*
  Checker for dmc_top: timing relations between commands, level and state reports.
  Assumes it is bound to dmc_top and sees only that module's ports.
*/
`include "dmc_map.vh"

module dmc_top_monitor (
  input wire       clock,
  input wire       reset_n,
  input wire [1:0] cfg_function,
  input wire       cfg_auto_en,
  input wire       cfg_lock_en,
  input wire [1:0] cfg_send_mode,
  input wire       restart,
  input wire       bus_fail,
  input wire       sw_valid,
  input wire       scene_valid,
  input wire       slumber_valid,
  input wire       ovr_valid,
  input wire [7:0] ovr_level,
  input wire [15:0] ovr_fade_s,
  input wire       auto_act_valid,
  input wire       auto_act_value,
  input wire       auto_val_valid,
  input wire       read_req,
  input wire       avail_scene,
  input wire       avail_auto,
  input wire       avail_slumber,
  input wire       avail_lock,
  input wire [7:0] level,
  input wire       fading,
  input wire       night_q,
  input wire       auto_on_q,
  input wire       ovr_q,
  input wire       auto_st_send_q,
  input wire       st_sw_send_q,
  input wire       st_sw_value_q,
  input wire       st_val_send_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  // Higher-priority commands would legitimately win over the one under test.
  wire quiet = !(restart || bus_fail || sw_valid || scene_valid || slumber_valid);

  a_stair_lock_only: assert property (cfg_function == `DMC_FN_STAIR |->
    !(avail_scene || avail_auto || avail_slumber)) else $error("staircase offers extra features");
  a_dim_features: assert property (cfg_function == `DMC_FN_DIM |->
    avail_lock == cfg_lock_en && avail_auto == cfg_auto_en) else $error("dimmer feature missing");
  a_none_silent: assert property ((cfg_send_mode == `DMC_SEND_NONE &&
    $past(cfg_send_mode, 3) == `DMC_SEND_NONE) |-> !(st_sw_send_q || st_val_send_q))
    else $error("state sent while reporting disabled");
  a_read_only: assert property ((cfg_send_mode == `DMC_SEND_READ &&
    $past(cfg_send_mode, 3) == `DMC_SEND_READ && !$past(read_req) && !$past(read_req, 2))
    |-> !(st_sw_send_q || st_val_send_q)) else $error("spontaneous send in read-only mode");
  a_on_report: assert property ((cfg_send_mode == `DMC_SEND_CHG &&
    $past(cfg_send_mode, 3) == `DMC_SEND_CHG && $past(level) == 8'h00 && level != 8'h00)
    |-> ##[0:2] (st_sw_send_q && st_sw_value_q)) else $error("no ON report on leaving zero");
  a_zero_fade: assert property ((cfg_function == `DMC_FN_DIM && quiet && ovr_valid &&
    ovr_fade_s == 16'h0000 && ovr_level <= `DMC_LVL_FULL) |=> level == $past(ovr_level))
    else $error("zero fade not applied at once");
  a_auto_held: assert property ((ovr_q && auto_val_valid && quiet && !ovr_valid &&
    !auto_act_valid && !fading) |=> $stable(level)) else $error("auto value taken in override");
  a_auto_state: assert property ((cfg_function == `DMC_FN_DIM && cfg_auto_en &&
    auto_act_valid && !restart) |=> auto_st_send_q && auto_on_q == $past(auto_act_value))
    else $error("auto mode state not reported");
  a_restart_day: assert property (restart |=> !night_q) else $error("not in day mode");
endmodule // dmc_top_monitor

bind dmc_top dmc_top_monitor u_mon (.*);

// file: test/test_dmc_top.sv
/*
  Testbench for dmc_top: telegram sequences with expected levels and state reports.
  Assumes a 10-cycle tick, so one second is 1000 clock cycles.
*/
module test_dmc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock = 1'b0, reset_n = 1'b0, restart = 1'b0, bus_fail = 1'b0;
  logic [1:0] cfg_function = 2'h1, cfg_send_mode = 2'h2, cfg_return_mode = 2'h2;
  logic [1:0] cfg_on_off_beh = 2'h1, cfg_on_on_beh = 2'h2;
  logic cfg_scene_en = 1'b1, cfg_auto_en = 1'b1, cfg_slumber_en = 1'b1, cfg_lock_en = 1'b1;
  logic cfg_fail_dim = 1'b1, cfg_off_dim = 1'b1, cfg_off2_en = 1'b0;
  logic [7:0] cfg_fail_level = 8'h05, cfg_return_level = 8'h28, cfg_on_level = 8'h3C;
  logic [7:0] cfg_night_on_level = 8'h32, cfg_off_level = 8'h14, cfg_night_off_level = 8'h00;
  logic [15:0] cfg_cycle_s = 16'h0001, cfg_on_fade_s = 16'h0000, cfg_off_fade_s = 16'h0000;
  logic [15:0] cfg_fallback_s = 16'h0002, cfg_slp_on_fade0_s = 16'h0001;
  logic [15:0] cfg_slp_on_fade1_s = 16'h0002, cfg_slp_off_fade0_s = 16'h0001;
  logic [15:0] cfg_slp_off_fade1_s = 16'h0002;
  logic slumber_valid = 1'b0, slumber_on = 1'b0, slumber_sel = 1'b0;
  logic day_night_valid = 1'b0, day_night_value = 1'b1;
  wire sw_valid, sw_value, scene_valid, ovr_valid, auto_act_valid, auto_act_value;
  wire auto_val_valid, read_req, avail_scene, avail_auto, avail_slumber, avail_lock;
  wire fading, night_q, auto_on_q, ovr_q, auto_st_send_q, st_sw_send_q, st_sw_value_q;
  wire st_val_send_q;
  wire [5:0] scene_num;
  wire [7:0] scene_level, ovr_level, auto_val, level, st_val_value_q;
  wire [15:0] ovr_fade_s;
  int n_mismatch = 0, total_checks = 0, n_sw = 0, n_val = 0, cs, cv, i;

  dmc_top #(.TICK_CYC(21'h00000A)) DUT (.*);
  dmc_knx_sender u_knx (.*);

  always #4 clock = ~clock;
  always @(posedge clock) begin
    if (st_sw_send_q === 1'b1) n_sw++;
    if (st_val_send_q === 1'b1) n_val++;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic go(input int k, input logic [15:0] a, input logic [15:0] b);
    u_knx.send(k, a, b);
    repeat (3) @(negedge clock);
  endtask

  task automatic pulse(input bit rs);
    @(negedge clock);
    if (rs) restart = 1'b1;
    else bus_fail = 1'b1;
    @(negedge clock);
    {restart, bus_fail} = 2'h0;
    repeat (3) @(negedge clock);
  endtask

  task automatic slp(input bit up, input bit alt);
    @(negedge clock);
    {slumber_valid, slumber_on, slumber_sel} = {1'b1, up, alt};
    @(negedge clock);
    slumber_valid = 1'b0;
    repeat (205) @(negedge clock);
  endtask

  initial begin
    #200000;
    n_mismatch++;
    conclude();
  end

  initial begin
    repeat (5) @(negedge clock);
    reset_n = 1'b1;
    chk(level, 8'h00);
    chk({4'h0, avail_scene, avail_auto, avail_slumber, avail_lock}, 8'h0F);
    cfg_function = 2'h2;
    @(negedge clock);
    chk({4'h0, avail_scene, avail_auto, avail_slumber, avail_lock}, 8'h01);
    cfg_function = 2'h0;
    @(negedge clock);
    chk({4'h0, avail_scene, avail_auto, avail_slumber, avail_lock}, 8'h00);
    cfg_function = 2'h1;
    go(0, 1, 0);
    chk(level, 8'h3C);
    chk({7'h00, st_sw_value_q}, 8'h01);
    chk(st_val_value_q, 8'h3C);
    chk(n_sw[7:0], 8'h01);
    cfg_on_level = 8'h28;
    go(0, 1, 0);
    chk(level, 8'h3C);
    cfg_on_on_beh = 2'h1;
    go(0, 1, 0);
    chk(level, 8'h28);
    cfg_on_on_beh = 2'h2;
    cfg_on_level = 8'h50;
    go(0, 1, 0);
    chk(level, 8'h50);
    go(0, 0, 0);
    chk(level, 8'h14);
    go(0, 0, 0);
    chk(level, 8'h00);
    chk({7'h00, st_sw_value_q}, 8'h00);
    {cfg_off_dim, cfg_off2_en} = 2'b01;
    // Let the window of the earlier OFF run out so the next OFF is a first one.
    repeat (1200) @(negedge clock);
    go(0, 1, 0);
    go(0, 0, 0);
    chk(level, 8'h50);
    repeat (1200) @(negedge clock);
    go(0, 0, 0);
    chk(level, 8'h50);
    go(0, 0, 0);
    chk(level, 8'h00);
    {cfg_on_off_beh, cfg_on_level} = {2'h2, 8'h3C};
    go(0, 1, 0);
    chk(level, 8'h50);
    go(1, 16'h0000, 16'h0019);
    chk(level, 8'h19);
    go(1, 16'h0010, 16'h005A);
    chk(level, 8'h19);
    go(2, 16'h0000, 16'h0000);
    chk(level, 8'h00);
    {cfg_on_off_beh, cfg_on_level, cfg_on_fade_s} = {2'h1, 8'h64, 16'h0001};
    cv = n_val;
    go(0, 1, 0);
    repeat (500) @(negedge clock);
    chk({7'h00, fading}, 8'h01);
    chk({7'h00, level >= 8'h28 && level <= 8'h3C}, 8'h01);
    chk({7'h00, n_val - cv <= 1}, 8'h01);
    go(2, 16'h000A, 16'h0000);
    chk(level, 8'h0A);
    cfg_on_fade_s = 16'h0000;
    go(3, 1, 0);
    chk({7'h00, auto_on_q}, 8'h01);
    go(4, 16'h001E, 0);
    chk(level, 8'h1E);
    go(0, 1, 0);
    chk({7'h00, ovr_q}, 8'h01);
    chk(level, 8'h64);
    go(4, 16'h001E, 0);
    chk(level, 8'h64);
    repeat (900) @(negedge clock);
    chk({7'h00, ovr_q}, 8'h01);
    for (i = 0; i < 3000 && ovr_q !== 1'b0; i++) @(negedge clock);
    if (ovr_q !== 1'b0) begin
      n_mismatch++;
      conclude();
    end
    go(4, 16'h001E, 0);
    chk(level, 8'h1E);
    go(3, 0, 0);
    chk({7'h00, auto_on_q}, 8'h00);
    cfg_send_mode = 2'h0;
    @(negedge clock);
    {cs, cv} = {n_sw, n_val};
    go(2, 16'h0000, 0);
    go(2, 16'h0032, 0);
    chk(8'(n_sw + n_val - cs - cv), 8'h00);
    cfg_send_mode = 2'h1;
    {cs, cv} = {n_sw, n_val};
    go(2, 16'h0046, 0);
    chk(8'(n_sw + n_val - cs - cv), 8'h00);
    go(5, 0, 0);
    chk(8'(n_val - cv), 8'h01);
    chk(st_val_value_q, 8'h46);
    cfg_send_mode = 2'h3;
    cv = n_val;
    repeat (2500) @(negedge clock);
    chk({7'h00, n_val - cv >= 2}, 8'h01);
    pulse(1'b0);
    chk(level, 8'h05);
    pulse(1'b1);
    chk(level, 8'h46);
    @(negedge clock);
    {day_night_valid, day_night_value} = 2'b10;
    @(negedge clock);
    day_night_valid = 1'b0;
    chk({7'h00, night_q}, 8'h01);
    cfg_return_mode = 2'h1;
    pulse(1'b1);
    chk(level, 8'h28);
    chk({7'h00, night_q}, 8'h00);
    slp(1'b1, 1'b1);
    chk({7'h00, level >= 8'h30 && level <= 8'h34}, 8'h01);
    slp(1'b0, 1'b0);
    chk({7'h00, level >= 8'h1B && level <= 8'h21}, 8'h01);
    conclude();
  end
endmodule // test_dmc_top
